/* File: irq_params.svh */
// Purpose: offsets, field positions, reset values, timing counts
// Assumes: 20 MHz system clock
// Notes: included by the level filter, the pulse block and the bench
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REG_DEVICE_STATUS_REG 8'h00
`define REG_SUP_STAT 8'h04
`define REG_THERM 8'h08
`define REG_BUS 8'h0c
`define REG_HS 8'h10
`define REG_DRAIN_SOURCE_OVERVOLT_REG 8'h14
`define REG_WAKE 8'h18
`define REG_MASK 8'h1c
`define REG_CTRL 8'h20
`define REG_WKCFG 8'h24
`define REG_IRQ_STAT 8'h28
`define REG_IRQ_MASK 8'h2c
`define REG_INFO 8'h30
// ----------------------------------------------------------------
// latched status vector layout
// ----------------------------------------------------------------
`define F_DEV 0
`define F_SUP 2
`define F_THERM 10
`define F_BUS 14
`define F_HS 18
`define F_DRAIN_SOURCE_OVERVOLT_REG 22
`define F_WAKE 30
`define W_ALL 38
`define SUP_NOIRQ 8'h0f
`define THERM_NOIRQ 4'h8
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_MASK 6'h3f
`define RST_CYC_EN 1'b1
`define RST_WKCFG 8'h00
`define RST_IRQ_MASK 2'h0
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SYS_CLK_KHZ 20000
`define T_INTERRUPT_OUT_N_US 100
`define T_GAP_US 100
`define T_PERIOD_MS 5
`define T_SDM_FILT_US 64
`define INTERRUPT_OUT_N_CYC ((`T_INTERRUPT_OUT_N_US * `SYS_CLK_KHZ) / 1000)
`define GAP_CYC ((`T_GAP_US * `SYS_CLK_KHZ + 999) / 1000)
`define T_PERIOD_CYC (`T_PERIOD_MS * `SYS_CLK_KHZ)
`define SDM_FILT_CYC ((`T_SDM_FILT_US * `SYS_CLK_KHZ + 999) / 1000)
`endif

/* File: irq_pkg.sv */
// Purpose: shared types of the interrupt pulse block
// Assumes: nothing
// Notes: constants live in irq_params.svh
package irq_pkg;
    typedef logic [16:0] tick_t;
    typedef enum logic [2:0] {
        mode_init = 3'h0,
        mode_normal = 3'h1,
        mode_stop = 3'h2,
        mode_sleep = 3'h3,
        mode_restart = 3'h4,
        mode_failsafe = 3'h5
    } op_mode_t;
    typedef enum logic [2:0] {
        st_idle = 3'h1,
        st_low = 3'h2,
        st_gap = 3'h4
    } pulse_state_t;
endpackage : irq_pkg

/* File: cycle_timer.sv */
// Purpose: one-shot cycle counter with done pulse
// Assumes: limit of at least one
// Notes: done comes limit cycles after start
`timescale 1ns/100ps
module cycle_timer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // control
    input wire logic start,
    input wire irq_pkg::tick_t limit,
    output logic running,
    output logic done
);
    irq_pkg::tick_t cnt_ff;
    logic run_ff;
    logic hit;

    assign hit = run_ff && (cnt_ff == limit - 17'h00001);
    assign running = run_ff;
    assign done = hit;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= 17'h00000;
            run_ff <= 1'b0;
        end else if (start) begin
            cnt_ff <= 17'h00000;
            run_ff <= 1'b1;
        end else if (hit) begin
            run_ff <= 1'b0;
        end else if (run_ff) begin
            cnt_ff <= cnt_ff + 17'h00001;
        end
    end
endmodule : cycle_timer

/* File: level_filter.sv */
// Purpose: accepts a pin level once stable long enough
// Assumes: din synchronous to sys_clk
// Notes: accepted pulses once per stable stretch
`timescale 1ns/100ps
`include "irq_params.svh"
module level_filter (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // sampling
    input wire logic enable,
    input wire logic din,
    output logic level,
    output logic accepted
);
    irq_pkg::tick_t cnt_ff;
    logic cand_ff;
    logic stable;
    logic reach;

    assign stable = enable && (din == cand_ff);
    assign reach = stable && (cnt_ff == 17'(`SDM_FILT_CYC - 1));
    assign level = cand_ff;
    assign accepted = reach;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= 17'h00000;
            cand_ff <= 1'b1;
        end else begin
            cand_ff <= din;
            if (!stable) begin
                cnt_ff <= 17'h00000;
            end else if (cnt_ff < 17'(`SDM_FILT_CYC)) begin
                cnt_ff <= cnt_ff + 17'h00001;
            end
        end
    end
endmodule : level_filter

/* File: interrupt_pulse_signaling.sv */
// Purpose: active-low interrupt pulse generator with status latches
// Assumes: inputs synchronous to sys_clk, events one cycle wide
// Notes: pin is an input while in init mode
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`include "irq_params.svh"
module interrupt_pulse_signaling #(
    parameter int PERIOD_CYCLES = `T_PERIOD_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // device mode
    input wire logic [2:0] op_mode,
    // event sources
    input wire logic [1:0] dev_evt,
    input wire logic [7:0] sup_evt,
    input wire logic [3:0] therm_evt,
    input wire logic [3:0] bus_evt,
    input wire logic [3:0] hs_evt,
    input wire logic [7:0] drain_source_overvolt_reg_evt,
    input wire logic [7:0] wake_evt,
    // interrupt pin
    input wire logic interrupt_in,
    output logic interrupt_out_n,
    output logic interrupt_oe_n,
    // status outputs
    output logic software_dev_mode,
    output logic irq
);
    localparam int LOW_CYCLES = `INTERRUPT_OUT_N_CYC;
    localparam int GAP_CYCLES = `GAP_CYC;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [31:0] f_word(input logic [7:0] v);
        f_word = {24'h000000, v};
    endfunction : f_word

    function automatic logic f_hit(input logic [7:0] a,
                                   input logic [7:0] off);
        f_hit = (a == off);
    endfunction : f_hit

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    irq_pkg::pulse_state_t state_ff, nxt_state;
    logic [`W_ALL-1:0] live_ff, nxt_live, shown_ff, nxt_shown;
    logic [`W_ALL-1:0] evt_vec, clr_vec;
    logic [5:0] mask_ff;
    logic cyc_en_ff;
    logic [7:0] wkcfg_ff;
    logic [1:0] irq_stat_ff, irq_mask_ff, irq_set, irq_clr;
    logic [2:0] mode_prev_ff;
    logic req_ff, nxt_req, pin_ff, oe_n_ff, irq_ff, sdm_ff;
    logic [31:0] rdata_ff, rd_mux;
    logic [5:0] grp_new;
    logic active, stop_entry, pulse_start, trig_ok;
    logic evt_trig, stop_trig, cyc_trig, low_end;
    logic tmr_done, per_running, per_done;
    logic flt_level, flt_accept;
    logic wr_dev, wr_sup, wr_therm, wr_bus, wr_hs, wr_drain_source_overvolt_reg, wr_wake;
    logic wr_mask, wr_ctrl, wr_wkcfg, wr_istat, wr_imask;

    // ------------------------------------------------------------
    // mode qualification
    // ------------------------------------------------------------
    assign active = (op_mode == irq_pkg::mode_normal) ||
                    (op_mode == irq_pkg::mode_stop);
    assign stop_entry = (op_mode == irq_pkg::mode_stop) &&
                        (mode_prev_ff != irq_pkg::mode_stop);

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    assign wr_dev = reg_wr && f_hit(reg_addr, `REG_DEVICE_STATUS_REG);
    assign wr_sup = reg_wr && f_hit(reg_addr, `REG_SUP_STAT);
    assign wr_therm = reg_wr && f_hit(reg_addr, `REG_THERM);
    assign wr_bus = reg_wr && f_hit(reg_addr, `REG_BUS);
    assign wr_hs = reg_wr && f_hit(reg_addr, `REG_HS);
    assign wr_drain_source_overvolt_reg = reg_wr && f_hit(reg_addr, `REG_DRAIN_SOURCE_OVERVOLT_REG);
    assign wr_wake = reg_wr && f_hit(reg_addr, `REG_WAKE);
    assign wr_mask = reg_wr && f_hit(reg_addr, `REG_MASK);
    assign wr_ctrl = reg_wr && f_hit(reg_addr, `REG_CTRL);
    assign wr_wkcfg = reg_wr && f_hit(reg_addr, `REG_WKCFG);
    assign wr_istat = reg_wr && f_hit(reg_addr, `REG_IRQ_STAT);
    assign wr_imask = reg_wr && f_hit(reg_addr, `REG_IRQ_MASK);

    // ------------------------------------------------------------
    // status latches
    // ------------------------------------------------------------
    assign evt_vec = {wake_evt, drain_source_overvolt_reg_evt, hs_evt, bus_evt,
                      therm_evt, sup_evt, dev_evt};
    assign clr_vec = {reg_wdata[7:0] & {8{wr_wake}},
                      reg_wdata[7:0] & {8{wr_drain_source_overvolt_reg}},
                      reg_wdata[3:0] & {4{wr_hs}},
                      reg_wdata[3:0] & {4{wr_bus}},
                      reg_wdata[3:0] & {4{wr_therm}},
                      reg_wdata[7:0] & {8{wr_sup}},
                      reg_wdata[1:0] & {2{wr_dev}}};
    // set wins over a clear in the same cycle
    assign nxt_live = (live_ff & ~clr_vec) | evt_vec;
    assign nxt_shown = pulse_start ? nxt_live :
                       (shown_ff & ~clr_vec);

    // ------------------------------------------------------------
    // interrupt triggers
    // ------------------------------------------------------------
    assign grp_new = {|dev_evt, |drain_source_overvolt_reg_evt, |hs_evt, |bus_evt,
                      |(therm_evt & ~`THERM_NOIRQ),
                      |(sup_evt & ~`SUP_NOIRQ)};
    assign pulse_start = (state_ff == irq_pkg::st_idle) &&
                         req_ff && active;
    // events during the low phase or at its start merge
    assign trig_ok = active && !pulse_start &&
                     (state_ff != irq_pkg::st_low);
    assign evt_trig = trig_ok && (|(grp_new & mask_ff) ||
                      |(wake_evt & wkcfg_ff));
    assign stop_trig = trig_ok && stop_entry &&
                       (|live_ff[`F_WAKE +: 8] ||
                        |live_ff[`F_DRAIN_SOURCE_OVERVOLT_REG +: 4]);
    assign cyc_trig = trig_ok && per_done && cyc_en_ff &&
                      |live_ff[`F_DEV +: 2];
    assign nxt_req = (req_ff && active && !pulse_start) ||
                     evt_trig || stop_trig || cyc_trig;

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    assign low_end = (state_ff == irq_pkg::st_low) && tmr_done;

    cycle_timer u_pulse_tmr (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .start(pulse_start || (low_end && active)),
        .limit(irq_pkg::tick_t'(LOW_CYCLES)),
        .running(),
        .done(tmr_done)
    );

    cycle_timer u_period_tmr (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .start(pulse_start || per_done || !per_running),
        .limit(irq_pkg::tick_t'(PERIOD_CYCLES)),
        .running(per_running),
        .done(per_done)
    );

    level_filter u_sdm_flt (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .enable(op_mode == irq_pkg::mode_init),
        .din(interrupt_in),
        .level(flt_level),
        .accepted(flt_accept)
    );

    // ------------------------------------------------------------
    // pulse sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            irq_pkg::st_idle: begin
                if (pulse_start) begin
                    nxt_state = irq_pkg::st_low;
                end
            end
            irq_pkg::st_low: begin
                if (!active) begin
                    nxt_state = irq_pkg::st_idle;
                end else if (tmr_done) begin
                    nxt_state = irq_pkg::st_gap;
                end
            end
            irq_pkg::st_gap: begin
                if (tmr_done) begin
                    nxt_state = irq_pkg::st_idle;
                end
            end
            default: nxt_state = irq_pkg::st_idle;
        endcase
    end

    // ------------------------------------------------------------
    // block interrupt
    // ------------------------------------------------------------
    assign irq_set = {flt_accept && (op_mode == irq_pkg::mode_init),
                      pulse_start};
    assign irq_clr = reg_wdata[1:0] & {2{wr_istat}};

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    assign rd_mux =
        f_hit(reg_addr, `REG_DEVICE_STATUS_REG) ?
            f_word({6'h00, shown_ff[`F_DEV +: 2]}) :
        f_hit(reg_addr, `REG_SUP_STAT) ?
            f_word(shown_ff[`F_SUP +: 8]) :
        f_hit(reg_addr, `REG_THERM) ?
            f_word({4'h0, shown_ff[`F_THERM +: 4]}) :
        f_hit(reg_addr, `REG_BUS) ?
            f_word({4'h0, shown_ff[`F_BUS +: 4]}) :
        f_hit(reg_addr, `REG_HS) ?
            f_word({4'h0, shown_ff[`F_HS +: 4]}) :
        f_hit(reg_addr, `REG_DRAIN_SOURCE_OVERVOLT_REG) ?
            f_word(shown_ff[`F_DRAIN_SOURCE_OVERVOLT_REG +: 8]) :
        f_hit(reg_addr, `REG_WAKE) ?
            f_word(shown_ff[`F_WAKE +: 8]) :
        f_hit(reg_addr, `REG_MASK) ? f_word({2'h0, mask_ff}) :
        f_hit(reg_addr, `REG_CTRL) ? f_word({7'h00, cyc_en_ff}) :
        f_hit(reg_addr, `REG_WKCFG) ? f_word(wkcfg_ff) :
        f_hit(reg_addr, `REG_IRQ_STAT) ?
            f_word({6'h00, irq_stat_ff}) :
        f_hit(reg_addr, `REG_IRQ_MASK) ?
            f_word({6'h00, irq_mask_ff}) :
        f_hit(reg_addr, `REG_INFO) ?
            f_word({1'b0, state_ff, 2'h0, req_ff, sdm_ff}) :
        32'h00000000;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= irq_pkg::st_idle;
            live_ff <= '0;
            shown_ff <= '0;
            req_ff <= 1'b0;
            mode_prev_ff <= irq_pkg::mode_init;
        end else begin
            state_ff <= nxt_state;
            live_ff <= nxt_live;
            shown_ff <= nxt_shown;
            req_ff <= nxt_req;
            mode_prev_ff <= op_mode;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mask_ff <= `RST_MASK;
            cyc_en_ff <= `RST_CYC_EN;
            wkcfg_ff <= `RST_WKCFG;
            irq_mask_ff <= `RST_IRQ_MASK;
        end else begin
            if (wr_mask) mask_ff <= reg_wdata[5:0];
            if (wr_ctrl) cyc_en_ff <= reg_wdata[0];
            if (wr_wkcfg) wkcfg_ff <= reg_wdata[7:0];
            if (wr_imask) irq_mask_ff <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat_ff <= 2'h0;
            irq_ff <= 1'b0;
            sdm_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
            if (irq_set[1]) sdm_ff <= !flt_level;
            rdata_ff <= reg_rd ? rd_mux : 32'h00000000;
        end
    end

    // pin drives low only in the low phase, floats in init
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_ff <= 1'b1;
            oe_n_ff <= 1'b1;
        end else begin
            pin_ff <= (nxt_state != irq_pkg::st_low);
            oe_n_ff <= (op_mode == irq_pkg::mode_init);
        end
    end

    assign interrupt_out_n = pin_ff;
    assign interrupt_oe_n = oe_n_ff;
    assign software_dev_mode = sdm_ff;
    assign irq = irq_ff;
    assign reg_rdata = rdata_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    irq_pkg::tick_t low_len_ff, gap_len_ff, since_ff;
    logic act_d_ff;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            low_len_ff <= 17'h00000;
            gap_len_ff <= 17'h1ffff;
            since_ff <= 17'h00000;
            act_d_ff <= 1'b0;
        end else begin
            act_d_ff <= active;
            low_len_ff <= pin_ff ? 17'h00000 : low_len_ff + 17'h00001;
            if (!pin_ff) gap_len_ff <= 17'h00000;
            else if (gap_len_ff != 17'h1ffff)
                gap_len_ff <= gap_len_ff + 17'h00001;
            if (pulse_start) since_ff <= 17'h00000;
            else if (since_ff != 17'h1ffff)
                since_ff <= since_ff + 17'h00001;
        end
    end

    sequence s_in_low;
        (state_ff == irq_pkg::st_low) [*2];
    endsequence

    sequence s_pulse_done;
        $rose(pin_ff) && act_d_ff && active;
    endsequence

    property p_low_width;
        @(posedge sys_clk) disable iff (!resetn)
        s_pulse_done |-> int'(low_len_ff) == LOW_CYCLES;
    endproperty
    a_low_width: assert property (p_low_width)
        else $error("pulse low time wrong");

    property p_gap;
        @(posedge sys_clk) disable iff (!resetn)
        $fell(pin_ff) |-> int'(gap_len_ff) >= GAP_CYCLES;
    endproperty
    a_gap: assert property (p_gap)
        else $error("pulse gap too short");

    property p_quiet;
        @(posedge sys_clk) disable iff (!resetn)
        !active |=> pin_ff && !req_ff;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("pulse outside normal or stop");

    property p_stop;
        @(posedge sys_clk) disable iff (!resetn)
        stop_entry && (state_ff == irq_pkg::st_idle) && !req_ff &&
        (|live_ff[`F_WAKE +: 8]) |=> req_ff ##1 !pin_ff;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop entry did not pulse");

    property p_snap;
        @(posedge sys_clk) disable iff (!resetn)
        $fell(pin_ff) |-> shown_ff == live_ff;
    endproperty
    a_snap: assert property (p_snap)
        else $error("status not refreshed at fall");

    property p_latch;
        @(posedge sys_clk) disable iff (!resetn)
        1'b1 |=> ((($past(live_ff) & ~$past(clr_vec))) & ~live_ff) == '0;
    endproperty
    a_latch: assert property (p_latch)
        else $error("latched event lost");

    property p_cause;
        @(posedge sys_clk) disable iff (!resetn)
        $rose(req_ff) && !$past(evt_trig) && !$past(stop_trig) |->
        $past(cyc_en_ff) && ((($past(live_ff) >> `F_DEV) & 38'h3) != 38'h0);
    endproperty
    a_cause: assert property (p_cause)
        else $error("reminder without pending failure");

    property p_period;
        @(posedge sys_clk) disable iff (!resetn)
        $rose(req_ff) && !$past(evt_trig) && !$past(stop_trig) |->
        int'(since_ff) >= PERIOD_CYCLES - 1;
    endproperty
    a_period: assert property (p_period)
        else $error("reminder too early");

    property p_merge;
        @(posedge sys_clk) disable iff (!resetn)
        s_in_low |-> !req_ff;
    endproperty
    a_merge: assert property (p_merge)
        else $error("second pulse queued during low");

    property p_noirq;
        @(posedge sys_clk) disable iff (!resetn)
        !req_ff && (state_ff == irq_pkg::st_idle) && !stop_entry &&
        !per_done && (dev_evt == 2'h0) && (bus_evt == 4'h0) &&
        (hs_evt == 4'h0) && (drain_source_overvolt_reg_evt == 8'h00) &&
        (wake_evt == 8'h00) && ((sup_evt & ~`SUP_NOIRQ) == 8'h00) &&
        ((therm_evt & ~`THERM_NOIRQ) == 4'h0) |=> !req_ff;
    endproperty
    a_noirq: assert property (p_noirq)
        else $error("excluded source raised a pulse");

    property p_sdm;
        @(posedge sys_clk) disable iff (!resetn)
        $changed(sdm_ff) |-> $past(op_mode) == irq_pkg::mode_init;
    endproperty
    a_sdm: assert property (p_sdm)
        else $error("mode select outside init");
endmodule : interrupt_pulse_signaling

/* File: host_mcu.sv */
// Purpose: host side of the interrupt pin
// Assumes: pin pulled up while the block does not drive it
// Notes: dev_sel makes the host strap the pin low
`timescale 1ns/100ps
module host_mcu (
    // pin as seen by the block
    input wire logic pin_out_n,
    input wire logic pin_oe_n,
    output logic pin_level,
    // host strap control
    input wire logic dev_sel
);
    // pull-up unless strapped low, push-pull when driven
    assign pin_level = pin_oe_n ? !dev_sel : pin_out_n;
endmodule : host_mcu

/* File: interrupt_pulse_signaling_test.sv */
// Purpose: self-checking bench of the interrupt pulse block
// Assumes: reminder period shortened to 5000 cycles
// Notes: expected read values are queued and compared by a monitor
`timescale 1ns/100ps
`include "irq_params.svh"
module interrupt_pulse_signaling_test;
    localparam int PER = 5000;
    logic sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, r;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, exp_q[$];
    logic [2:0] op_mode = 3'h1;
    logic [37:0] evt = 38'h0;
    logic interrupt_in, interrupt_out_n, interrupt_oe_n;
    logic software_dev_mode, irq, dev_sel = 1'b0, rd_seen = 1'b0;
    int bad_count = 0, tests_run = 0, cyc_n = 0, n, t0;
    host_mcu host (.pin_out_n(interrupt_out_n), .pin_oe_n(interrupt_oe_n),
        .pin_level(interrupt_in), .dev_sel);
    interrupt_pulse_signaling #(.PERIOD_CYCLES(PER)) uut (.sys_clk,
        .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .op_mode, .dev_evt(evt[1:0]), .sup_evt(evt[9:2]),
        .therm_evt(evt[13:10]), .bus_evt(evt[17:14]), .hs_evt(evt[21:18]),
        .drain_source_overvolt_reg_evt(evt[29:22]), .wake_evt(evt[37:30]), .interrupt_in,
        .interrupt_out_n, .interrupt_oe_n, .software_dev_mode, .irq);
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // ----
    // checking and closing
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    always @(posedge sys_clk) begin
        cyc_n <= cyc_n + 1;
        rd_seen <= reg_rd;
        if (rd_seen) chk(reg_rdata, exp_q.pop_front());
        if (cyc_n == 60000) begin
            bad_count++;
            test_done();
        end
    end
    // ----
    // drivers
    // ----
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask : rd
    task automatic ev(input int f, input logic [7:0] v);
        @(posedge sys_clk);
        evt <= 38'(v) << f;
        @(posedge sys_clk);
        evt <= 38'h0;
    endtask : ev
    task automatic wfall(input int lim);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (interrupt_out_n !== 1'b0 && n < lim);
    endtask : wfall
    task automatic wlow;
        while (interrupt_out_n === 1'b0 && cyc_n < 60000) @(negedge sys_clk);
    endtask : wlow
    initial begin
        void'($urandom(32'hb964));
        r = 8'($urandom_range(15, 1));
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(8'h1c, 32'h3f);
        rd(8'h20, 32'h1);
        rd(8'h3c, 32'h0);
        wr(8'h2c, 32'h1);
        ev(`F_HS, r);
        wfall(10);
        chk(n, 2);
        t0 = cyc_n;
        ev(`F_DEV, 8'h03);
        rd(8'h10, r);
        rd(8'h00, 32'h0);
        chk(irq, 1'b1);
        wr(8'h28, 32'h1);
        repeat (2) @(negedge sys_clk);
        chk(irq, 1'b0);
        wlow;
        chk(cyc_n - t0, `INTERRUPT_OUT_N_CYC);
        wfall(2500);
        chk(interrupt_out_n, 1'b1);
        wfall(1000);
        chk((cyc_n - t0) inside {[PER - 2:PER + 2]}, 1'b1);
        rd(8'h00, 32'h3);
        wlow;
        wr(8'h20, 32'h0);
        wfall(6000);
        chk(interrupt_out_n, 1'b1);
        wr(8'h00, 32'h3);
        wr(8'h20, 32'h1);
        rd(8'h00, 32'h0);
        wfall(6000);
        chk(interrupt_out_n, 1'b1);
        for (int m = 3; m < 6; m++) begin
            @(posedge sys_clk) op_mode <= 3'(m);
            ev(`F_BUS, 8'h0f);
            wfall(100);
            chk(interrupt_out_n, 1'b1);
        end
        @(posedge sys_clk) op_mode <= 3'h1;
        ev(`F_SUP, 8'h0f);
        ev(`F_THERM, 8'h08);
        ev(`F_WAKE, 8'hff);
        wfall(100);
        chk(interrupt_out_n, 1'b1);
        ev(`F_DRAIN_SOURCE_OVERVOLT_REG, 8'h01);
        wfall(10);
        chk(n, 2);
        wlow;
        wfall(2100);
        wr(8'h24, 32'h1);
        ev(`F_WAKE, 8'h01);
        wfall(10);
        chk(n, 2);
        wlow;
        wfall(2100);
        @(posedge sys_clk) op_mode <= 3'h2;
        wfall(10);
        chk(interrupt_out_n, 1'b0);
        wlow;
        @(posedge sys_clk) op_mode <= 3'h0;
        dev_sel <= 1'b1;
        repeat (1200) @(negedge sys_clk);
        chk(interrupt_oe_n, 1'b1);
        chk(software_dev_mode, 1'b0);
        repeat (100) @(negedge sys_clk);
        chk(software_dev_mode, 1'b1);
        test_done();
    end
endmodule : interrupt_pulse_signaling_test
